//--- core/icr_regs.sv
// Control register set of the image codec: start, config, mode, status
// Assumes host strobes come from pins, resynchronised here on MCLK
`timescale 1ns/10ps
`include "icr_defs.svh"
module icr_regs (
	// Clock, reset, enable
	input wire logic MCLK,
	input wire logic RSTN,
	input wire logic CE,
	// Host register port
	input wire logic CS_N,
	input wire logic WR_N,
	input wire logic RD_N,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] DATA_IN,
	output logic [7:0] DATA_OUT,
	output logic DATA_OE,
	// Datapath events
	input wire logic EV_RFM,
	input wire logic EV_RFD,
	input wire logic EV_END,
	input wire logic EV_TCVOVF,
	input wire logic EV_DATOVF,
	input wire logic EV_DATA_READY,
	input wire logic EV_DATA_TAKEN,
	input wire logic SCAN_DONE,
	// Compressed byte stream
	input wire logic BYTE_VALID,
	input wire logic [7:0] BYTE_DATA,
	output logic BYTE_DONE,
	output logic [7:0] CODE_OUT,
	output logic CODE_OE,
	output logic [7:0] BUS_DATA_OUT,
	output logic BUS_DATA_OE,
	// Pass control
	output logic [3:0] PASS_SEL,
	output logic RUN,
	output logic START_PULSE,
	output logic OVF_DETECT,
	output logic [3:0] SCAN_TOTAL,
	output logic [8:0] BLOCK_BIT_CAP,
	output logic RATE_CAP_ACTIVE,
	// Segment enables
	output logic EMIT_APP,
	output logic EMIT_COM,
	output logic RESTART_ACTIVE,
	output logic EMIT_DRI,
	output logic QUANT_LOAD,
	output logic EMIT_DQT,
	output logic EMIT_DHT,
	output logic EMIT_DNL,
	output logic HUFF_LOAD,
	// Interrupt and status pins
	output logic INT_N,
	output logic DINT_N,
	output logic END_N
);
	logic [2:0] cs_sync_ff;
	logic [2:0] wr_sync_ff;
	logic [2:0] rd_sync_ff;
	logic [7:0] addr_s1_ff;
	logic [7:0] addr_ff;
	logic [7:0] din_s1_ff;
	logic [7:0] din_ff;
	logic wr_stb;
	logic rd_stb;
	logic go;
	logic status_rd;
	logic [7:0] xfer_ff;
	logic [7:0] mode_ff;
	logic [7:0] opts_ff;
	logic [7:0] limit_ff;
	logic [7:0] mark_ff;
	logic [7:0] intreq_ff;
	logic [7:0] status_ff;
	logic [7:0] rdata_ff;
	logic rdoe_ff;
	logic int_ff;
	logic first_scan_ff;
	logic halt_req;
	logic comp;
	logic tables_only;
	logic compress_pass;
	icr_pkg::icr_state_type state_ff;
	icr_pkg::icr_state_type nxt_state;
	icr_pkg::icr_pass_type pass;
	icr_lane_if lif ();

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	function automatic icr_pkg::icr_pass_type decode_pass(input logic [7:0] m);
		icr_pkg::icr_pass_type p;
		p = icr_pkg::ICR_PASS_NONE;
		if (m[`ICR_MD_COMP]) begin
			if (m[`ICR_MD_TLM]) begin
				p = m[`ICR_MD_SECOND_PASS_SELECT] ? icr_pkg::ICR_PASS_TABLES_ONLY :
					icr_pkg::ICR_PASS_PRELOAD_ENC;
			end else if (m[`ICR_MD_ATP] && m[`ICR_MD_BRC] && !m[`ICR_MD_SECOND_PASS_SELECT]) begin
				p = icr_pkg::ICR_PASS_AUTO_RATE;
			end else if (m[`ICR_MD_SECOND_PASS_SELECT]) begin
				p = m[`ICR_MD_BRC] ? icr_pkg::ICR_PASS_RATE_COMP :
					icr_pkg::ICR_PASS_COMPRESS;
			end else if (m[`ICR_MD_BRC]) begin
				p = icr_pkg::ICR_PASS_STATS;
			end
		end else begin
			if (m[`ICR_MD_TLM]) begin
				p = icr_pkg::ICR_PASS_PRELOAD_DEC;
			end else if (m[`ICR_MD_DC]) begin
				p = icr_pkg::ICR_PASS_PREVIEW;
			end else begin
				p = icr_pkg::ICR_PASS_EXPAND;
			end
		end
		decode_pass = p;
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			cs_sync_ff <= 3'h7;
			wr_sync_ff <= 3'h7;
			rd_sync_ff <= 3'h7;
			addr_s1_ff <= 8'h00;
			addr_ff <= 8'h00;
			din_s1_ff <= 8'h00;
			din_ff <= 8'h00;
		end else if (CE) begin
			cs_sync_ff <= {cs_sync_ff[1:0], CS_N};
			wr_sync_ff <= {wr_sync_ff[1:0], WR_N};
			rd_sync_ff <= {rd_sync_ff[1:0], RD_N};
			addr_s1_ff <= ADDR;
			addr_ff <= addr_s1_ff;
			din_s1_ff <= DATA_IN;
			din_ff <= din_s1_ff;
		end
	end

	// Falling edges taken between second and third stages
	assign wr_stb = !cs_sync_ff[1] && !wr_sync_ff[1] && wr_sync_ff[2];
	assign rd_stb = !cs_sync_ff[1] && !rd_sync_ff[1] && rd_sync_ff[2];
	assign go = wr_stb && hit(addr_ff, `ICR_OFF_START);
	assign status_rd = rd_stb && hit(addr_ff, `ICR_OFF_STATUS);

	// ----------------------------------------
	// Writable registers
	// ----------------------------------------
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			xfer_ff <= `ICR_RST_XFER;
			mode_ff <= `ICR_RST_MODE;
			opts_ff <= `ICR_RST_OPTS;
			limit_ff <= `ICR_RST_LIMIT;
			mark_ff <= `ICR_RST_MARK;
			intreq_ff <= `ICR_RST_INTREQ;
		end else if (CE && wr_stb) begin
			if (hit(addr_ff, `ICR_OFF_XFER)) xfer_ff <= din_ff & 8'hFD;
			if (hit(addr_ff, `ICR_OFF_MODE)) mode_ff <= din_ff & 8'hFC;
			if (hit(addr_ff, `ICR_OFF_OPTS)) opts_ff <= din_ff & 8'hF0;
			if (hit(addr_ff, `ICR_OFF_LIMIT)) limit_ff <= din_ff;
			if (hit(addr_ff, `ICR_OFF_MARK)) mark_ff <= din_ff;
			if (hit(addr_ff, `ICR_OFF_INTREQ)) intreq_ff <= din_ff & 8'h9F;
		end
	end

	// ----------------------------------------
	// Status register, set wins over clear
	// ----------------------------------------
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			status_ff <= `ICR_RST_STATUS;
		end else if (CE) begin
			if (go || status_rd) begin
				status_ff <= status_ff & ~`ICR_ST_CLR_MASK;
			end
			if (go) begin
				status_ff[`ICR_ST_END] <= 1'b0;
			end
			if (status_rd || EV_DATA_TAKEN) begin
				status_ff[`ICR_ST_RDY] <= 1'b0;
			end
			if (EV_RFM) status_ff[`ICR_ST_RFM] <= 1'b1;
			if (EV_RFD) status_ff[`ICR_ST_RFD] <= 1'b1;
			if (EV_END) status_ff[`ICR_ST_END] <= 1'b1;
			if (EV_TCVOVF && opts_ff[`ICR_OP_OVF]) status_ff[`ICR_ST_TCV] <= 1'b1;
			if (EV_DATOVF) status_ff[`ICR_ST_DOV] <= 1'b1;
			if (EV_DATA_READY) status_ff[`ICR_ST_RDY] <= 1'b1;
		end
	end

	// Enabled events other than data-ready halt processing
	assign halt_req = CE && |({EV_RFM, EV_RFD, EV_END, EV_TCVOVF && opts_ff[`ICR_OP_OVF],
		EV_DATOVF} & {intreq_ff[`ICR_ST_RFM], intreq_ff[`ICR_ST_RFD],
		intreq_ff[`ICR_ST_END], intreq_ff[`ICR_ST_TCV], intreq_ff[`ICR_ST_DOV]});

	// ----------------------------------------
	// Interrupt line
	// ----------------------------------------
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			int_ff <= 1'b0;
		end else if (CE) begin
			if (halt_req) begin
				int_ff <= 1'b1;
			end else if (go || status_rd) begin
				int_ff <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Run state machine
	// ----------------------------------------
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			icr_pkg::ICR_ST_IDLE: begin
				if (go) nxt_state = icr_pkg::ICR_ST_RUN;
			end
			icr_pkg::ICR_ST_RUN: begin
				if (halt_req) nxt_state = icr_pkg::ICR_ST_HALT;
				else if (EV_END || EV_DATOVF) nxt_state = icr_pkg::ICR_ST_IDLE;
			end
			icr_pkg::ICR_ST_HALT: begin
				if (go) nxt_state = icr_pkg::ICR_ST_RUN;
			end
			default: nxt_state = icr_pkg::ICR_ST_IDLE;
		endcase
	end

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			state_ff <= icr_pkg::ICR_ST_IDLE;
		end else if (CE) begin
			state_ff <= nxt_state;
		end
	end

	// ----------------------------------------
	// First-scan tracking
	// ----------------------------------------
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			first_scan_ff <= 1'b1;
		end else if (CE) begin
			if (go && state_ff == icr_pkg::ICR_ST_IDLE) begin
				first_scan_ff <= 1'b1;
			end else if (SCAN_DONE) begin
				first_scan_ff <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			rdata_ff <= 8'h00;
			rdoe_ff <= 1'b0;
		end else if (CE) begin
			rdoe_ff <= !cs_sync_ff[1] && !rd_sync_ff[1];
			if (rd_stb) begin
				case (addr_ff)
					`ICR_OFF_XFER: rdata_ff <= xfer_ff;
					`ICR_OFF_MODE: rdata_ff <= mode_ff;
					`ICR_OFF_OPTS: rdata_ff <= opts_ff;
					`ICR_OFF_LIMIT: rdata_ff <= limit_ff;
					`ICR_OFF_MARK: rdata_ff <= mark_ff;
					`ICR_OFF_INTREQ: rdata_ff <= intreq_ff;
					`ICR_OFF_STATUS: rdata_ff <= status_ff;
					default: rdata_ff <= 8'h00;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Decoded controls
	// ----------------------------------------
	assign comp = mode_ff[`ICR_MD_COMP];
	assign pass = decode_pass(mode_ff);
	assign tables_only = (pass == icr_pkg::ICR_PASS_TABLES_ONLY);
	assign compress_pass = (pass == icr_pkg::ICR_PASS_COMPRESS) ||
		(pass == icr_pkg::ICR_PASS_RATE_COMP);

	assign PASS_SEL = pass;
	assign RUN = (state_ff == icr_pkg::ICR_ST_RUN);
	assign START_PULSE = go && CE;
	assign OVF_DETECT = comp && opts_ff[`ICR_OP_OVF];
	assign SCAN_TOTAL = comp ? {1'b0, opts_ff[`ICR_OP_SCN_HI:`ICR_OP_SCN_LO]} + 4'h1 : 4'h1;
	assign BLOCK_BIT_CAP = {limit_ff, 1'b0};
	assign RATE_CAP_ACTIVE = comp && mode_ff[`ICR_MD_BRC];
	assign EMIT_APP = mark_ff[`ICR_MK_APP] && (compress_pass || tables_only);
	assign EMIT_COM = mark_ff[`ICR_MK_COM] && (compress_pass || tables_only);
	assign RESTART_ACTIVE = mark_ff[`ICR_MK_DRI];
	assign EMIT_DRI = mark_ff[`ICR_MK_DRI] && compress_pass;
	assign QUANT_LOAD = mark_ff[`ICR_MK_DQT] || mark_ff[`ICR_MK_INTERNAL_QUANT_LOAD];
	assign EMIT_DQT = mark_ff[`ICR_MK_DQT] && (compress_pass || tables_only);
	assign EMIT_DHT = mark_ff[`ICR_MK_DHT] && (compress_pass || tables_only);
	assign EMIT_DNL = mark_ff[`ICR_MK_DNL] && compress_pass && first_scan_ff;
	assign HUFF_LOAD = mark_ff[`ICR_MK_INTERNAL_HUFFMAN_LOAD];
	assign INT_N = !int_ff;
	assign DINT_N = !(status_ff[`ICR_ST_RDY] && intreq_ff[`ICR_ST_RDY]);
	assign END_N = !status_ff[`ICR_ST_END];
	assign DATA_OUT = rdata_ff;
	assign DATA_OE = rdoe_ff;

	// ----------------------------------------
	// Compressed byte lanes
	// ----------------------------------------
	assign lif.xfer_cfg = xfer_ff;
	assign lif.byte_valid = BYTE_VALID && RUN;
	assign lif.byte_data = BYTE_DATA;
	assign BYTE_DONE = lif.cycle_done && CE;
	assign CODE_OUT = lif.code_out;
	assign CODE_OE = lif.code_oe;
	assign BUS_DATA_OUT = lif.data_out;
	assign BUS_DATA_OE = lif.data_oe;

	icr_lane u_lane (
		.clk(MCLK),
		.rst_n(RSTN),
		.ce(CE),
		.lif(lif)
	);
endmodule

//--- pkg/icr_defs.svh
// Register offsets, field positions and reset values
// Assumes inclusion by bare name from the modules
`ifndef ICR_DEFS_SVH
`define ICR_DEFS_SVH
`define ICR_ADDR_W 8
`define ICR_OFF_START 8'h00
`define ICR_OFF_XFER 8'h01
`define ICR_OFF_MODE 8'h02
`define ICR_OFF_OPTS 8'h03
`define ICR_OFF_LIMIT 8'h04
`define ICR_OFF_MARK 8'h05
`define ICR_OFF_INTREQ 8'h06
`define ICR_OFF_STATUS 8'h07
`define ICR_RST_XFER 8'h00
`define ICR_RST_MODE 8'h00
`define ICR_RST_OPTS 8'h00
`define ICR_RST_LIMIT 8'h00
`define ICR_RST_MARK 8'h00
`define ICR_RST_INTREQ 8'h00
`define ICR_RST_STATUS 8'h04
// Transfer config fields
`define ICR_XF_WIDE 7
`define ICR_XF_MASTER_TRANSFER_SELECT 6
`define ICR_XF_DMA 5
`define ICR_XF_CYC_HI 4
`define ICR_XF_CYC_LO 2
`define ICR_XF_LANE 0
// Mode fields
`define ICR_MD_COMP 7
`define ICR_MD_ATP 6
`define ICR_MD_SECOND_PASS_SELECT 5
`define ICR_MD_TLM 4
`define ICR_MD_DC 3
`define ICR_MD_BRC 2
// Options fields
`define ICR_OP_SCN_HI 7
`define ICR_OP_SCN_LO 5
`define ICR_OP_OVF 4
// Marker enable fields
`define ICR_MK_APP 7
`define ICR_MK_COM 6
`define ICR_MK_DRI 5
`define ICR_MK_DQT 4
`define ICR_MK_DHT 3
`define ICR_MK_DNL 2
`define ICR_MK_INTERNAL_QUANT_LOAD 1
`define ICR_MK_INTERNAL_HUFFMAN_LOAD 0
// Status fields
`define ICR_ST_RDY 7
`define ICR_ST_RFM 4
`define ICR_ST_RFD 3
`define ICR_ST_END 2
`define ICR_ST_TCV 1
`define ICR_ST_DOV 0
`define ICR_ST_CLR_MASK 8'h1B
`endif

//--- pkg/icr_pkg.sv
// Types shared by the control register block
// Encodings given as literals here; icr_defs.svh is not used
package icr_pkg;
	typedef enum logic [3:0] {
		ICR_PASS_NONE = 4'h0,
		ICR_PASS_COMPRESS = 4'h1,
		ICR_PASS_AUTO_RATE = 4'h3,
		ICR_PASS_STATS = 4'h2,
		ICR_PASS_RATE_COMP = 4'h6,
		ICR_PASS_TABLES_ONLY = 4'h7,
		ICR_PASS_PRELOAD_ENC = 4'h5,
		ICR_PASS_EXPAND = 4'h4,
		ICR_PASS_PREVIEW = 4'hC,
		ICR_PASS_PRELOAD_DEC = 4'hD
	} icr_pass_type;
	typedef enum logic [1:0] {
		ICR_XF_MASTER = 2'h0,
		ICR_XF_SLAVE8 = 2'h1,
		ICR_XF_SLAVE16 = 2'h3
	} icr_xfer_type;
	typedef enum logic [1:0] {
		ICR_ST_IDLE = 2'h0,
		ICR_ST_RUN = 2'h1,
		ICR_ST_HALT = 2'h3
	} icr_state_type;
endpackage

//--- pkg/icr_lane_if.sv
// Interface between control core and compressed-byte lane steering
// Assumes a single clock domain
`timescale 1ns/10ps
interface icr_lane_if;
	logic [7:0] xfer_cfg;
	logic byte_valid;
	logic [7:0] byte_data;
	logic cycle_done;
	logic [7:0] data_out;
	logic data_oe;
	logic [7:0] code_out;
	logic code_oe;
	modport core (output xfer_cfg, output byte_valid, output byte_data,
		input cycle_done, input data_out, input data_oe, input code_out, input code_oe);
	modport lane (input xfer_cfg, input byte_valid, input byte_data,
		output cycle_done, output data_out, output data_oe, output code_out, output code_oe);
endinterface

//--- core/icr_lane.sv
// Steers compressed bytes onto data or code bus and paces master cycles
// Assumes MCLK domain, byte_valid held until cycle_done
`timescale 1ns/10ps
`include "icr_defs.svh"
module icr_lane (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Core side
	icr_lane_if.lane lif
);
	logic [2:0] cyc_cnt_ff;
	logic odd_ff;
	logic [7:0] data_ff;
	logic [7:0] code_ff;
	logic doe_ff;
	logic coe_ff;
	logic master_transfer_select;
	logic wide;
	logic lane;
	logic [2:0] cyc_len;
	logic use_code;

	assign master_transfer_select = lif.xfer_cfg[`ICR_XF_MASTER_TRANSFER_SELECT];
	assign wide = lif.xfer_cfg[`ICR_XF_WIDE];
	assign lane = lif.xfer_cfg[`ICR_XF_LANE];
	assign cyc_len = lif.xfer_cfg[`ICR_XF_CYC_HI:`ICR_XF_CYC_LO];
	// Master cycle ends after field plus one clocks, slave cycle at once
	assign lif.cycle_done = lif.byte_valid && (!master_transfer_select || cyc_cnt_ff == cyc_len);
	// Bus choice per mode and byte parity
	assign use_code = master_transfer_select || (wide && (odd_ff ^ lane));

	// ----------------------------------------
	// Master cycle counter
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cyc_cnt_ff <= 3'h0;
		end else if (ce) begin
			if (lif.cycle_done || !lif.byte_valid) begin
				cyc_cnt_ff <= 3'h0;
			end else begin
				cyc_cnt_ff <= cyc_cnt_ff + 3'h1;
			end
		end
	end

	// ----------------------------------------
	// Byte parity and output registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			odd_ff <= 1'b0;
			data_ff <= 8'h00;
			code_ff <= 8'h00;
			doe_ff <= 1'b0;
			coe_ff <= 1'b0;
		end else if (ce) begin
			doe_ff <= 1'b0;
			coe_ff <= 1'b0;
			if (lif.byte_valid) begin
				if (use_code) begin
					code_ff <= lif.byte_data;
					coe_ff <= 1'b1;
				end else begin
					data_ff <= lif.byte_data;
					doe_ff <= 1'b1;
				end
			end
			if (lif.cycle_done) begin
				odd_ff <= wide ? ~odd_ff : 1'b0;
			end
		end
	end

	assign lif.data_out = data_ff;
	assign lif.code_out = code_ff;
	assign lif.data_oe = doe_ff;
	assign lif.code_oe = coe_ff;
endmodule

//--- testbench/icr_host.sv
// Host processor model driving the register port pins
// Assumes MCLK domain; tasks are called from the testbench
`timescale 1ns/10ps
module icr_host (
	// Clock
	input wire logic MCLK,
	// Host pins
	output logic CS_N,
	output logic WR_N,
	output logic RD_N,
	output logic [7:0] ADDR,
	output logic [7:0] DATA_IN,
	input wire logic [7:0] DATA_OUT
);
	initial begin
		CS_N = 1'b1;
		WR_N = 1'b1;
		RD_N = 1'b1;
		ADDR = 8'h00;
		DATA_IN = 8'h00;
	end
	// ----------------------------------------
	// Bus cycles
	// ----------------------------------------
	task wr(input logic [7:0] a, input logic [7:0] d);
		repeat (2) @(posedge MCLK);
		ADDR <= a;
		DATA_IN <= (a == 8'h00) ? ~DATA_IN : d;
		CS_N <= 1'b0;
		repeat (3) @(posedge MCLK);
		WR_N <= 1'b0;
		repeat (4) @(posedge MCLK);
		WR_N <= 1'b1;
		repeat (3) @(posedge MCLK);
		CS_N <= 1'b1;
		DATA_IN <= ~DATA_IN;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		repeat (2) @(posedge MCLK);
		ADDR <= a;
		CS_N <= 1'b0;
		repeat (3) @(posedge MCLK);
		RD_N <= 1'b0;
		repeat (6) @(posedge MCLK);
		d = DATA_OUT;
		RD_N <= 1'b1;
		repeat (3) @(posedge MCLK);
		CS_N <= 1'b1;
	endtask
endmodule

//--- testbench/icr_regs_sva.sv
// Concurrent checks on the control register block ports
// Assumes one MCLK domain and RSTN active low
`timescale 1ns/10ps
module icr_regs_sva (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RSTN,
	// Observed ports
	input wire logic CS_N,
	input wire logic RD_N,
	input wire logic [7:0] ADDR,
	input wire logic EV_END,
	input wire logic START_PULSE,
	input wire logic RUN,
	input wire logic INT_N,
	input wire logic END_N,
	input wire logic [3:0] PASS_SEL,
	input wire logic [3:0] SCAN_TOTAL,
	input wire logic [8:0] BLOCK_BIT_CAP,
	input wire logic EMIT_DQT,
	input wire logic QUANT_LOAD,
	input wire logic RESTART_ACTIVE,
	input wire logic EMIT_DRI,
	input wire logic BYTE_DONE,
	input wire logic CODE_OE,
	input wire logic BUS_DATA_OE,
	input wire logic DATA_OE
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RSTN);
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_start_run: assert property (START_PULSE |=> RUN)
		else $error("start did not run");
	a_int_halts: assert property ($fell(INT_N) |-> !RUN)
		else $error("interrupt without halt");
	a_read_release: assert property ($fell(RD_N) && !CS_N && ADDR == 8'h07 |-> ##[2:8] INT_N)
		else $error("status read kept interrupt");
	a_start_end: assert property (START_PULSE && !EV_END |=> END_N)
		else $error("start kept end flag");
	a_byte_out: assert property (BYTE_DONE && RUN |=> CODE_OE || BUS_DATA_OE)
		else $error("accepted byte not driven");
	a_idle_byte: assert property (!RUN |-> !BYTE_DONE)
		else $error("byte taken outside run");
	a_dec_scans: assert property (PASS_SEL == 4'h4 || PASS_SEL == 4'hC || PASS_SEL == 4'hD
		|-> SCAN_TOTAL == 4'h1)
		else $error("options active in decode");
	a_scan_range: assert property (SCAN_TOTAL >= 4'h1 && SCAN_TOTAL <= 4'h8)
		else $error("scan total out of range");
	a_cap_even: assert property (BLOCK_BIT_CAP[0] == 1'b0)
		else $error("block cap not doubled");
	a_dqt_loads: assert property (EMIT_DQT |-> QUANT_LOAD)
		else $error("emitted tables not loaded");
	a_dri_pair: assert property (EMIT_DRI == (RESTART_ACTIVE && (PASS_SEL == 4'h1 ||
		PASS_SEL == 4'h6)))
		else $error("restart and segment differ");
	a_read_drive: assert property ($fell(RD_N) && !CS_N |-> ##[2:4] DATA_OE)
		else $error("read data not driven");
	c_start: cover property (START_PULSE);
	c_int: cover property ($fell(INT_N));
	c_code: cover property (CODE_OE);
	c_data: cover property (BUS_DATA_OE);
endmodule
bind icr_regs icr_regs_sva u_sva (.MCLK, .RSTN, .CS_N, .RD_N, .ADDR, .EV_END, .START_PULSE,
	.RUN, .INT_N, .END_N, .PASS_SEL, .SCAN_TOTAL, .BLOCK_BIT_CAP, .EMIT_DQT, .QUANT_LOAD,
	.RESTART_ACTIVE, .EMIT_DRI, .BYTE_DONE, .CODE_OE, .BUS_DATA_OE, .DATA_OE);

//--- testbench/test_icr_regs.sv
// Self-checking bench for the control register block
// Assumes host model drives the pins, bench drives events and bytes
`timescale 1ns/10ps
module test_icr_regs;
	logic MCLK = 1'b0;
	logic RSTN = 1'b0;
	logic [7:0] ev = 8'h00;
	logic BYTE_VALID = 1'b0;
	logic CE = 1'b1;
	logic [7:0] BYTE_DATA = 8'h00;
	logic CS_N, WR_N, RD_N, DATA_OE, BYTE_DONE, CODE_OE, BUS_DATA_OE, RUN, START_PULSE;
	logic [7:0] ADDR, DATA_IN, DATA_OUT, CODE_OUT, BUS_DATA_OUT, rv;
	logic [3:0] PASS_SEL, SCAN_TOTAL;
	logic [8:0] BLOCK_BIT_CAP;
	logic OVF_DETECT, RATE_CAP_ACTIVE, EMIT_APP, EMIT_COM, RESTART_ACTIVE, EMIT_DRI;
	logic QUANT_LOAD, EMIT_DQT, EMIT_DHT, EMIT_DNL, HUFF_LOAD, INT_N, DINT_N, END_N;
	logic [7:0] msk [1:6] = '{8'h5D, 8'hC4, 8'hF0, 8'hFF, 8'hFD, 8'h9F};
	logic [7:0] md [0:8] = '{8'hC4, 8'h84, 8'hA0, 8'hA4, 8'hB0, 8'h90, 8'h00, 8'h08, 8'h10};
	logic [3:0] ps [0:8] = '{4'h3, 4'h2, 4'h1, 4'h6, 4'h7, 4'h5, 4'h4, 4'hC, 4'hD};
	logic [8:0] mk [0:7] = '{9'h001, 9'h008, 9'h002, 9'h004, 9'h018, 9'h060, 9'h080, 9'h100};
	int n_fail = 0;
	int num_checks = 0;
	int n;
	always #25 MCLK = ~MCLK;
	icr_regs DUT (.MCLK, .RSTN, .CE, .CS_N, .WR_N, .RD_N, .ADDR, .DATA_IN, .DATA_OUT,
		.DATA_OE, .EV_RFM(ev[0]), .EV_RFD(ev[1]), .EV_END(ev[2]), .EV_TCVOVF(ev[3]),
		.EV_DATOVF(ev[4]), .EV_DATA_READY(ev[5]), .EV_DATA_TAKEN(ev[6]), .SCAN_DONE(ev[7]),
		.BYTE_VALID, .BYTE_DATA, .BYTE_DONE, .CODE_OUT, .CODE_OE, .BUS_DATA_OUT, .BUS_DATA_OE,
		.PASS_SEL, .RUN, .START_PULSE, .OVF_DETECT, .SCAN_TOTAL, .BLOCK_BIT_CAP,
		.RATE_CAP_ACTIVE, .EMIT_APP, .EMIT_COM, .RESTART_ACTIVE, .EMIT_DRI, .QUANT_LOAD,
		.EMIT_DQT, .EMIT_DHT, .EMIT_DNL, .HUFF_LOAD, .INT_N, .DINT_N, .END_N);
	icr_host HOST (.MCLK, .CS_N, .WR_N, .RD_N, .ADDR, .DATA_IN, .DATA_OUT);
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task chk1(input logic g, input logic e);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t: flag %b want %b", $time, g, e);
		end
	endtask
	task chk9(input logic [8:0] g, input logic [8:0] e);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t: value %h want %h", $time, g, e);
		end
	endtask
	task report_and_stop;
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task pulse(input int k);
		@(posedge MCLK);
		ev[k] <= 1'b1;
		@(posedge MCLK);
		ev <= 8'h00;
		@(negedge MCLK);
	endtask
	task xb(input logic [7:0] cfg, input logic [7:0] d, input logic code, input int cyc);
		HOST.wr(8'h01, cfg);
		n = 0;
		@(posedge MCLK);
		BYTE_VALID <= 1'b1;
		BYTE_DATA <= d;
		do begin
			@(negedge MCLK);
			n++;
		end while (BYTE_DONE !== 1'b1 && n < 20);
		@(posedge MCLK);
		BYTE_VALID <= 1'b0;
		@(negedge MCLK);
		chk1(CODE_OE, code);
		chk1(BUS_DATA_OE, !code);
		chk9({1'b0, code ? CODE_OUT : BUS_DATA_OUT}, {1'b0, d});
		chk9(n[8:0], cyc[8:0]);
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (5000) @(posedge MCLK);
		n_fail++;
		report_and_stop;
	end
	initial begin
		repeat (3) @(posedge MCLK);
		RSTN <= 1'b1;
		@(negedge MCLK);
		chk1(END_N, 1'b0);
		chk1(INT_N, 1'b1);
		for (int i = 1; i < 8; i++) begin
			HOST.rd(i[7:0], rv);
			chk9({1'b0, rv}, (i == 7) ? 9'h004 : 9'h000);
		end
		for (int i = 1; i < 7; i++) begin
			HOST.wr(i[7:0], msk[i]);
			HOST.rd(i[7:0], rv);
			chk9({1'b0, rv}, {1'b0, msk[i]});
		end
		HOST.wr(8'h20, 8'h5A);
		HOST.rd(8'h20, rv);
		chk9({1'b0, rv}, 9'h000);
		for (int i = 0; i < 9; i++) begin
			HOST.wr(8'h02, md[i]);
			chk9({5'h00, PASS_SEL}, {5'h00, ps[i]});
			chk9({5'h00, SCAN_TOTAL}, (i < 6) ? 9'h008 : 9'h001);
			chk1(OVF_DETECT, i < 6);
		end
		HOST.wr(8'h04, 8'h01);
		HOST.wr(8'h02, 8'hA4);
		chk9(BLOCK_BIT_CAP, 9'h002);
		chk1(RATE_CAP_ACTIVE, 1'b1);
		HOST.wr(8'h04, 8'hFF);
		chk9(BLOCK_BIT_CAP, 9'h1FE);
		HOST.wr(8'h02, 8'hA0);
		HOST.wr(8'h03, 8'hE0);
		chk1(RATE_CAP_ACTIVE, 1'b0);
		chk1(OVF_DETECT, 1'b0);
		HOST.wr(8'h06, 8'h90);
		HOST.wr(8'h00, 8'h00);
		chk1(RUN, 1'b1);
		chk1(END_N, 1'b1);
		for (int i = 0; i < 8; i++) begin
			HOST.wr(8'h05, 8'h01 << i);
			chk9({EMIT_APP, EMIT_COM, EMIT_DRI, RESTART_ACTIVE, EMIT_DQT, QUANT_LOAD, EMIT_DHT,
				EMIT_DNL, HUFF_LOAD}, mk[i]);
		end
		HOST.wr(8'h05, 8'h04);
		pulse(7);
		chk1(EMIT_DNL, 1'b0);
		xb(8'h80, 8'h11, 1'b0, 1);
		xb(8'h80, 8'h22, 1'b1, 1);
		xb(8'h81, 8'h33, 1'b1, 1);
		xb(8'h81, 8'h44, 1'b0, 1);
		xb(8'h00, 8'hA5, 1'b0, 1);
		xb(8'h20, 8'h5A, 1'b0, 1);
		xb(8'h40, 8'hC3, 1'b1, 1);
		xb(8'h4C, 8'h3C, 1'b1, 4);
		xb(8'h5C, 8'h96, 1'b1, 8);
		pulse(0);
		chk1(INT_N, 1'b0);
		chk1(RUN, 1'b0);
		HOST.wr(8'h00, 8'h00);
		chk1(RUN, 1'b1);
		chk1(INT_N, 1'b1);
		pulse(0);
		HOST.rd(8'h07, rv);
		chk9({1'b0, rv}, 9'h010);
		chk1(INT_N, 1'b1);
		chk1(RUN, 1'b0);
		HOST.wr(8'h00, 8'h00);
		pulse(5);
		chk1(DINT_N, 1'b0);
		chk1(RUN, 1'b1);
		HOST.wr(8'h00, 8'h00);
		chk1(DINT_N, 1'b0);
		HOST.rd(8'h07, rv);
		chk9({1'b0, rv}, 9'h080);
		chk1(DINT_N, 1'b1);
		CE <= 1'b0;
		pulse(0);
		chk1(INT_N, 1'b1);
		chk1(RUN, 1'b1);
		CE <= 1'b1;
		pulse(5);
		chk1(DINT_N, 1'b0);
		pulse(6);
		chk1(DINT_N, 1'b1);
		HOST.wr(8'h06, 8'h92);
		pulse(3);
		chk1(INT_N, 1'b1);
		chk1(RUN, 1'b1);
		HOST.wr(8'h03, 8'h10);
		pulse(3);
		chk1(INT_N, 1'b0);
		chk1(RUN, 1'b0);
		HOST.rd(8'h07, rv);
		chk9({1'b0, rv}, 9'h002);
		HOST.wr(8'h00, 8'h00);
		chk1(RUN, 1'b1);
		pulse(4);
		pulse(1);
		HOST.rd(8'h07, rv);
		chk9({1'b0, rv}, 9'h009);
		chk1(RUN, 1'b0);
		HOST.wr(8'h00, 8'h00);
		chk1(RUN, 1'b1);
		pulse(2);
		chk1(END_N, 1'b0);
		chk1(INT_N, 1'b1);
		report_and_stop;
	end
endmodule
